/* design/sfi_front.sv */
// Serial flash front end: pin sync, mode, shifting, address unit, receive FIFO
// Functional notes
// [RULE_01] Single-line input on line 0, sampled at rising clock.
// [RULE_02] Single-line read data and status leave on line 1.
// [RULE_03] Host clock modes (0,0) and (1,1) both work.
// [RULE_04] Opcode 35h enters four-line mode from single-command mode.
// [RULE_05] Opcode: eight clocks on one line, two on four.
// [RULE_06] One mode at a time; F5h leaves; quad-enable bit ignored.
// [RULE_07] Every reset returns to single-line operation.
// [RULE_08] Four-line mode: all four pins are data lanes 0 to 3.
// [RULE_09] Double-edge reads move address and data on both edges.
// [RULE_10] Erased locations read as all ones.
// [RULE_11] Erase granules: 4K, 32K, 64K, whole chip.
// [RULE_12] Program writes 1 to 256 bytes within one page.
// [RULE_13] Read bursts of 8, 16, 32, 64 bytes wrap in aligned window.
// [RULE_14] Host drops select after power-up; nothing taken while high.
// [RULE_15] Select high: outputs released, standby.
// [RULE_16] Single-line output changes on falling clock.
// [RULE_17] Most significant bit first on every lane width.
// [RULE_18] Mode bit changes only by enter, leave opcodes and resets.
`timescale 1ns/1ps
`default_nettype none

module sfi_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 8
) (
  input  wire logic             clk,
  input  wire logic             reset_n,
  input  wire logic [WIDTH-1:0] inData,
  input  wire logic             inValid,
  output logic                  inReady,
  output logic      [WIDTH-1:0] outData,
  output logic                  outValid,
  input  wire logic             outReady
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wrIdx_q;
  logic [AW-1:0]    rdIdx_q;
  logic [AW:0]      count_q;
  logic             push;
  logic             pop;

  // Full and empty from the count
  assign inReady  = (count_q != (AW+1)'(DEPTH));
  assign outValid = (count_q != '0);
  assign outData  = mem_q[rdIdx_q];
  assign push     = inValid & inReady;
  assign pop      = outValid & outReady;

  // Storage, written by index
  always_ff @(posedge clk)
  begin
    if (push)
    begin
      mem_q[wrIdx_q] <= inData;
    end
  end

  // Pointers wrap at any depth
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      wrIdx_q <= '0;
      rdIdx_q <= '0;
    end
    else
    begin
      if (push)
      begin
        wrIdx_q <= (wrIdx_q == AW'(DEPTH - 1)) ? '0 : wrIdx_q + AW'(1);
      end
      if (pop)
      begin
        rdIdx_q <= (rdIdx_q == AW'(DEPTH - 1)) ? '0 : rdIdx_q + AW'(1);
      end
    end
  end

  // Occupancy
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      count_q <= '0;
    end
    else if (push != pop)
    begin
      count_q <= push ? count_q + (AW+1)'(1) : count_q - (AW+1)'(1);
    end
  end
endmodule

module sfi_front #(
  parameter int FIFO_DEPTH = 8
) (
  input  wire logic                clk,
  input  wire logic                reset_n,
  input  wire logic                csN,
  input  wire logic                sck,
  input  wire logic                hwResetN,
  input  wire logic [3:0]          ioIn,
  output logic      [3:0]          ioOut,
  output logic      [3:0]          ioOeN,
  output logic                     wpN,
  output logic                     holdN,
  output logic                     fourLineMode,
  input  wire sfi_pkg::sfi_lanes_t bodyLanes,
  input  wire logic                dtrEnable,
  input  wire logic                txDrive,
  input  wire logic [7:0]          txData,
  input  wire logic                txValid,
  output logic                     txReady,
  output logic [7:0]               rxData,
  output logic                     rxIsOpcode,
  output logic                     rxValid,
  input  wire logic                rxReady,
  output logic                     rxSpace,
  output logic                     rxOverrun,
  input  wire logic                addrLoad,
  input  wire logic [23:0]         addrValue,
  input  wire logic                addrStep,
  input  wire logic                programMode,
  input  wire logic                wrapEnable,
  input  wire sfi_pkg::sfi_wrap_t  wrapSize,
  input  wire sfi_pkg::sfi_erase_t eraseKind,
  output logic [23:0]              curAddr,
  output logic [8:0]               pageBytes,
  output logic                     pageFull,
  output logic [23:0]              eraseFirst,
  output logic [23:0]              eraseLast
);
  import sfi_pkg::*;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [2:0] csSync_q;
  logic [2:0] sckSync_q;
  logic [2:0] hwrSync_q;
  logic [3:0] ioS1_q;
  logic [3:0] ioS2_q;
  logic [3:0] ioS3_q;
  logic       csF_q;
  logic       sckF_q;
  logic       hwrF_q;
  logic [3:0] ioF_q;
  logic       sckAgree;
  logic       sckRise;
  logic       sckFall;
  logic [3:0] ioNow;

  // Three stages; first stage feeds only the second
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      csSync_q  <= 3'h7;
      sckSync_q <= 3'h0;
      hwrSync_q <= 3'h7;
      ioS1_q    <= 4'hF;
      ioS2_q    <= 4'hF;
      ioS3_q    <= 4'hF;
    end
    else
    begin
      csSync_q  <= {csSync_q[1:0], csN};
      sckSync_q <= {sckSync_q[1:0], sck};
      hwrSync_q <= {hwrSync_q[1:0], hwResetN};
      ioS1_q    <= ioIn;
      ioS2_q    <= ioS1_q;
      ioS3_q    <= ioS2_q;
    end
  end

  // A level counts once stages two and three agree
  assign sckAgree = (sckSync_q[1] == sckSync_q[2]);
  assign sckRise  = sckAgree & sckSync_q[2] & ~sckF_q;   // [RULE_03]
  assign sckFall  = sckAgree & ~sckSync_q[2] & sckF_q;
  assign ioNow    = (ioS2_q & ~(ioS2_q ^ ioS3_q)) | (ioF_q & (ioS2_q ^ ioS3_q));

  // Filtered levels; idle clock gives no edge
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      csF_q  <= 1'b1;
      sckF_q <= 1'b0;
      hwrF_q <= 1'b1;
      ioF_q  <= 4'hF;
    end
    else
    begin
      if (csSync_q[1] == csSync_q[2])
      begin
        csF_q <= csSync_q[2];
      end
      if (sckAgree)
      begin
        sckF_q <= sckSync_q[2];
      end
      if (hwrSync_q[1] == hwrSync_q[2])
      begin
        hwrF_q <= hwrSync_q[2];
      end
      ioF_q <= ioNow;
    end
  end

  // ----------------------------------------------------------------
  // Frame sequencing
  // ----------------------------------------------------------------
  sfi_state_t st_q;
  logic       armed_q;
  logic       frameStart;
  logic       frameEnd;
  logic       ddrNow;
  logic       sampleEdge;
  logic       driveEdge;
  sfi_lanes_t lanes;
  logic       quad_q;
  logic [7:0] rxShift_q;
  logic [3:0] rxCnt_q;
  logic [7:0] rxNext;
  logic [3:0] rxCntNext;
  logic       byteDone;
  logic       swReset;
  logic       hwReset;

  assign frameStart = armed_q & ~csF_q & (st_q == ST_IDLE);   // [RULE_14]
  assign frameEnd   = csF_q & (st_q != ST_IDLE);
  assign ddrNow     = dtrEnable & (st_q == ST_BODY);
  assign sampleEdge = (st_q != ST_IDLE) & ~csF_q & (sckRise | (ddrNow & sckFall));   // [RULE_01] [RULE_09]
  assign driveEdge  = (st_q == ST_BODY) & ~csF_q & (sckFall | (ddrNow & sckRise));   // [RULE_16] [RULE_09]
  assign hwReset    = ~hwrF_q;

  // Lane count: mode, then body setting
  always_comb
  begin
    if (quad_q)
    begin
      lanes = LANE_FOUR;   // [RULE_05] [RULE_08]
    end
    else if (st_q == ST_OPCODE)
    begin
      lanes = LANE_ONE;   // [RULE_05]
    end
    else
    begin
      lanes = bodyLanes;
    end
  end

  // One high select level needed after reset
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      armed_q <= 1'b0;
    end
    else if (csF_q)
    begin
      armed_q <= 1'b1;   // [RULE_14]
    end
  end

  // Idle while deselected, opcode first, then the body
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      st_q <= ST_IDLE;
    end
    else
    begin
      unique case (st_q)
        ST_IDLE:   st_q <= frameStart ? ST_OPCODE : ST_IDLE;
        ST_OPCODE: st_q <= csF_q ? ST_IDLE : (byteDone ? ST_BODY : ST_OPCODE);
        ST_BODY:   st_q <= csF_q ? ST_IDLE : ST_BODY;   // [RULE_15]
        default:   st_q <= ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Receive shifter
  // ----------------------------------------------------------------
  assign rxNext    = shiftIn(rxShift_q, ioNow, lanes);   // [RULE_17]
  assign rxCntNext = rxCnt_q + laneCount(lanes);
  assign byteDone  = sampleEdge & ~txDrive & (rxCntNext == BITS_PER_BYTE);

  // Partial bytes die with the frame
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rxShift_q <= 8'h00;
      rxCnt_q   <= 4'h0;
    end
    else if (csF_q)
    begin
      rxCnt_q <= 4'h0;
    end
    else if (sampleEdge & ~txDrive)
    begin
      rxShift_q <= rxNext;
      rxCnt_q   <= byteDone ? 4'h0 : rxCntNext;
    end
  end

  // ----------------------------------------------------------------
  // Mode control
  // ----------------------------------------------------------------
  logic pendEnter_q;
  logic pendLeave_q;
  logic rstArm_q;
  logic pendReset_q;
  logic opcDone;

  assign opcDone = byteDone & (st_q == ST_OPCODE);
  assign swReset = frameEnd & pendReset_q;

  // Opcodes act when the frame closes
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pendEnter_q <= 1'b0;
      pendLeave_q <= 1'b0;
      pendReset_q <= 1'b0;
      rstArm_q    <= 1'b0;
    end
    else if (hwReset)
    begin
      pendEnter_q <= 1'b0;
      pendLeave_q <= 1'b0;
      pendReset_q <= 1'b0;
      rstArm_q    <= 1'b0;
    end
    else if (opcDone)
    begin
      pendEnter_q <= (rxNext == OPC_ENTER_FOUR_LINE) & ~quad_q;   // [RULE_04]
      pendLeave_q <= (rxNext == OPC_LEAVE_FOUR_LINE) & quad_q;    // [RULE_06]
      pendReset_q <= (rxNext == OPC_RESET_GO) & rstArm_q;
      rstArm_q    <= (rxNext == OPC_RESET_ARM);
    end
    else if (frameEnd)
    begin
      pendEnter_q <= 1'b0;
      pendLeave_q <= 1'b0;
      pendReset_q <= 1'b0;
    end
  end

  // Single mode bit; quad-enable ignored
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      quad_q <= 1'b0;   // [RULE_07]
    end
    else if (hwReset | swReset)
    begin
      quad_q <= 1'b0;   // [RULE_07] [RULE_18]
    end
    else if (frameEnd & pendEnter_q)
    begin
      quad_q <= 1'b1;   // [RULE_04] [RULE_18]
    end
    else if (frameEnd & pendLeave_q)
    begin
      quad_q <= 1'b0;   // [RULE_06] [RULE_18]
    end
  end

  assign fourLineMode = quad_q;

  // Protect and hold pins only outside quad lanes
  assign wpN   = (quad_q | (lanes == LANE_FOUR)) ? 1'b1 : ioF_q[2];   // [RULE_08]
  assign holdN = (quad_q | (lanes == LANE_FOUR)) ? 1'b1 : ioF_q[3];   // [RULE_08]

  // ----------------------------------------------------------------
  // Transmit shifter
  // ----------------------------------------------------------------
  logic [7:0] txShift_q;
  logic [3:0] txCnt_q;
  logic [7:0] txByte;
  logic [3:0] txStep;
  logic       txLoad;

  assign txLoad  = driveEdge & txDrive & (txCnt_q == 4'h0);
  assign txReady = txLoad & txValid;
  assign txByte  = (txCnt_q != 4'h0) ? txShift_q : (txValid ? txData : ERASED_BYTE);   // [RULE_10]
  assign txStep  = laneCount(lanes);

  // Underrun sends the erased pattern
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      txShift_q <= 8'h00;
      txCnt_q   <= 4'h0;
    end
    else if (csF_q | ~txDrive)
    begin
      txCnt_q <= 4'h0;
    end
    else if (driveEdge)
    begin
      txShift_q <= txByte << txStep;   // [RULE_17]
      txCnt_q   <= ((txCnt_q == 4'h0) ? BITS_PER_BYTE : txCnt_q) - txStep;
    end
  end

  // Pin drivers; released while deselected
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ioOut <= 4'h0;
      ioOeN <= 4'hF;
    end
    else if (csF_q | ~txDrive | (st_q != ST_BODY))
    begin
      ioOeN <= 4'hF;   // [RULE_15]
    end
    else if (driveEdge)
    begin
      unique case (lanes)
        LANE_ONE:
        begin
          ioOut <= {2'b00, txByte[7], 1'b0};   // [RULE_02]
          ioOeN <= 4'b1101;
        end
        LANE_TWO:
        begin
          ioOut <= {2'b00, txByte[7:6]};
          ioOeN <= 4'b1100;
        end
        LANE_FOUR:
        begin
          ioOut <= txByte[7:4];   // [RULE_08]
          ioOeN <= 4'b0000;
        end
        default:
        begin
          ioOeN <= 4'hF;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Receive FIFO
  // ----------------------------------------------------------------
  logic [8:0] fifoOut;

  sfi_fifo #(
    .WIDTH (9),
    .DEPTH (FIFO_DEPTH)
  ) u_rx_fifo (
    .clk      (clk),
    .reset_n  (reset_n),
    .inData   ({st_q == ST_OPCODE, rxNext}),
    .inValid  (byteDone),
    .inReady  (rxSpace),
    .outData  (fifoOut),
    .outValid (rxValid),
    .outReady (rxReady)
  );

  assign rxData     = fifoOut[7:0];
  assign rxIsOpcode = fifoOut[8];

  // Host cannot stall, so overflow is flagged
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rxOverrun <= 1'b0;
    end
    else if (byteDone & ~rxSpace)
    begin
      rxOverrun <= 1'b1;
    end
    else if (frameStart)
    begin
      rxOverrun <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Address unit
  // ----------------------------------------------------------------
  logic [23:0] wrapMask;
  logic [23:0] eraseMask;

  // Burst window and erase granule sizes
  always_comb
  begin
    unique case (wrapSize)
      WRAP_8:  wrapMask = WRAP8_MASK;   // [RULE_13]
      WRAP_16: wrapMask = WRAP16_MASK;
      WRAP_32: wrapMask = WRAP32_MASK;
      WRAP_64: wrapMask = WRAP64_MASK;
    endcase
    unique case (eraseKind)
      ERASE_4K:   eraseMask = SECTOR_MASK;   // [RULE_11]
      ERASE_32K:  eraseMask = BLOCK32_MASK;
      ERASE_64K:  eraseMask = BLOCK64_MASK;
      ERASE_CHIP: eraseMask = CHIP_MASK;
    endcase
  end

  // Page wrap for program, window wrap for reads
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      curAddr   <= 24'h00_0000;
      pageBytes <= 9'h000;
    end
    else if (addrLoad)
    begin
      curAddr   <= addrValue;
      pageBytes <= 9'h000;
    end
    else if (addrStep)
    begin
      if (programMode)
      begin
        curAddr   <= wrapNext(curAddr, PAGE_MASK);   // [RULE_12]
        pageBytes <= (pageBytes == PAGE_BYTES) ? pageBytes : pageBytes + 9'h001;   // [RULE_12]
      end
      else if (wrapEnable)
      begin
        curAddr <= wrapNext(curAddr, wrapMask);   // [RULE_13]
      end
      else
      begin
        curAddr <= curAddr + ADDR_ONE;
      end
    end
  end

  assign pageFull = (pageBytes == PAGE_BYTES);

  // Aligned erase range
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      eraseFirst <= 24'h00_0000;
      eraseLast  <= 24'h00_0000;
    end
    else
    begin
      eraseFirst <= curAddr & ~eraseMask;   // [RULE_11]
      eraseLast  <= curAddr | eraseMask;
    end
  end
endmodule

`default_nettype wire

/* design/sfi_pkg.sv */
// Constants, types and helpers of the serial flash front end
package sfi_pkg;

  // ----------------------------------------------------------------
  // Opcodes seen by the front end
  // ----------------------------------------------------------------
  localparam logic [7:0] OPC_ENTER_FOUR_LINE = 8'h35;
  localparam logic [7:0] OPC_LEAVE_FOUR_LINE = 8'hF5;
  localparam logic [7:0] OPC_RESET_ARM       = 8'h66;
  localparam logic [7:0] OPC_RESET_GO        = 8'h99;

  // ----------------------------------------------------------------
  // Array facts
  // ----------------------------------------------------------------
  localparam logic [7:0]  ERASED_BYTE   = 8'hFF;
  localparam logic [8:0]  PAGE_BYTES    = 9'h100;
  localparam logic [23:0] PAGE_MASK     = 24'h00_00FF;
  localparam logic [23:0] SECTOR_MASK   = 24'h00_0FFF;
  localparam logic [23:0] BLOCK32_MASK  = 24'h00_7FFF;
  localparam logic [23:0] BLOCK64_MASK  = 24'h00_FFFF;
  localparam logic [23:0] CHIP_MASK     = 24'hFF_FFFF;
  localparam logic [23:0] WRAP8_MASK    = 24'h00_0007;
  localparam logic [23:0] WRAP16_MASK   = 24'h00_000F;
  localparam logic [23:0] WRAP32_MASK   = 24'h00_001F;
  localparam logic [23:0] WRAP64_MASK   = 24'h00_003F;
  localparam logic [23:0] ADDR_ONE      = 24'h00_0001;
  localparam logic [3:0]  BITS_PER_BYTE = 4'h8;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {LANE_ONE = 2'b00, LANE_TWO = 2'b01, LANE_FOUR = 2'b10} sfi_lanes_t;
  typedef enum logic [1:0] {ERASE_4K, ERASE_32K, ERASE_64K, ERASE_CHIP} sfi_erase_t;
  typedef enum logic [1:0] {WRAP_8, WRAP_16, WRAP_32, WRAP_64} sfi_wrap_t;
  typedef enum logic [1:0] {ST_IDLE = 2'b00, ST_OPCODE = 2'b01, ST_BODY = 2'b11} sfi_state_t;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [3:0] laneCount(sfi_lanes_t l);
    logic [3:0] n;
    n = 4'h1;
    unique case (l)
      LANE_ONE:  n = 4'h1;
      LANE_TWO:  n = 4'h2;
      LANE_FOUR: n = 4'h4;
      default:   n = 4'h1;
    endcase
    return n;
  endfunction

  // MSB first, on the highest lane
  function automatic logic [7:0] shiftIn(logic [7:0] sh, logic [3:0] io, sfi_lanes_t l);
    logic [7:0] r;
    r = {sh[6:0], io[0]};
    unique case (l)
      LANE_ONE:  r = {sh[6:0], io[0]};
      LANE_TWO:  r = {sh[5:0], io[1:0]};
      LANE_FOUR: r = {sh[3:0], io[3:0]};
      default:   r = {sh[6:0], io[0]};
    endcase
    return r;
  endfunction

  // Increment inside the mask's aligned window
  function automatic logic [23:0] wrapNext(logic [23:0] a, logic [23:0] m);
    return (a & ~m) | ((a + ADDR_ONE) & m);
  endfunction

endpackage

/* dv/sfi_front_assertions.sv */
// Port-level concurrent checks of the serial flash front end
`timescale 1ns/1ps
`default_nettype none
module sfi_front_checker
  import sfi_pkg::*;
#(
  parameter int FIFO_DEPTH = 8
) (
  input wire logic                clk,
  input wire logic                reset_n,
  input wire logic                csN,
  input wire logic                hwResetN,
  input wire logic [3:0]          ioOeN,
  input wire logic                fourLineMode,
  input wire sfi_pkg::sfi_lanes_t bodyLanes,
  input wire logic                dtrEnable,
  input wire logic                addrLoad,
  input wire logic [23:0]         addrValue,
  input wire logic                addrStep,
  input wire logic                programMode,
  input wire logic                wrapEnable,
  input wire sfi_pkg::sfi_wrap_t  wrapSize,
  input wire sfi_pkg::sfi_erase_t eraseKind,
  input wire logic [23:0]         curAddr,
  input wire logic [23:0]         eraseFirst,
  input wire logic [23:0]         eraseLast
);
  logic [23:0] eMask;
  logic [23:0] wMask;
  // -------------------------
  // Window masks of erase and wrap
  // -------------------------
  assign eMask = (eraseKind == ERASE_4K) ? SECTOR_MASK : (eraseKind == ERASE_32K) ? BLOCK32_MASK
               : (eraseKind == ERASE_64K) ? BLOCK64_MASK : CHIP_MASK;
  assign wMask = (wrapSize == WRAP_8) ? WRAP8_MASK : (wrapSize == WRAP_16) ? WRAP16_MASK
               : (wrapSize == WRAP_32) ? WRAP32_MASK : WRAP64_MASK;
  // One domain
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  property p_oeIdle;
    csN [*6] |-> ioOeN == 4'hF;
  endproperty
  a_oeIdle: assert property (p_oeIdle) else $error("pins driven while deselected");
  property p_single;
    !fourLineMode && bodyLanes == LANE_ONE && !dtrEnable && ioOeN != 4'hF |-> ioOeN == 4'b1101;
  endproperty
  a_single: assert property (p_single) else $error("single output off line 1");
  // Mode moves only between frames
  property p_modeHold;
    !$stable(fourLineMode) |-> csN;
  endproperty
  a_modeHold: assert property (p_modeHold) else $error("mode changed inside a frame");
  property p_hwReset;
    !hwResetN [*6] |-> !fourLineMode;
  endproperty
  a_hwReset: assert property (p_hwReset) else $error("mode kept in hw reset");
  property p_load;
    addrLoad |=> curAddr == $past(addrValue);
  endproperty
  a_load: assert property (p_load) else $error("address load lost");
  property p_wrap;
    addrStep && !addrLoad && !programMode && wrapEnable
      |=> curAddr == (($past(curAddr) & ~$past(wMask)) | (($past(curAddr) + 24'h00_0001) & $past(wMask)));
  endproperty
  a_wrap: assert property (p_wrap) else $error("burst step left its window");
  property p_page;
    addrStep && !addrLoad && programMode
      |=> curAddr[23:8] == $past(curAddr[23:8]) && curAddr[7:0] == $past(curAddr[7:0]) + 8'h01;
  endproperty
  a_page: assert property (p_page) else $error("program step left its page");
  property p_erase;
    1'b1 |=> eraseFirst == ($past(curAddr) & ~$past(eMask)) && eraseLast == ($past(curAddr) | $past(eMask));
  endproperty
  a_erase: assert property (p_erase) else $error("erase range misaligned");
endmodule
`default_nettype wire

/* dv/sfi_host.sv */
// Host controller model: chip select, serial clock and shared data pins
`timescale 1ns/1ps
`default_nettype none
module sfi_host (
  output logic            csN,
  output logic            sck,
  output logic      [3:0] ioIn,
  input  wire logic       clk,
  input  wire logic [3:0] ioOut,
  input  wire logic [3:0] ioOeN
);
  logic [3:0] hv;
  logic       hoe;
  logic       tog = 1'b0;
  logic       idleLvl;
  int         half = 6;
  // Deselected, clock parked low
  initial {csN, sck, hoe, idleLvl, hv} = 8'h80;
  // Released lines toggle, so stale data cannot pass
  always @(negedge clk) tog <= ~tog;
  // Pin level from both parties' enables
  assign ioIn = (~ioOeN & ioOut) | (ioOeN & (hoe ? hv : {4{tog}}));
  task automatic waitClk(input int n);
    repeat (n) @(negedge clk);
  endtask
  // Park clock at idle level, then select
  task automatic openFrame(input logic idle);
    idleLvl = idle;
    sck = idle;
    waitClk(half);
    csN = 1'b0;
    hoe = 1'b1;
    waitClk(half);
  endtask
  // One byte, MSB first; line 1 read before each rise
  task automatic xfer(input logic [7:0] b, input int lanes, output logic [7:0] r);
    for (int i = 0; i < 8 / lanes; i++)
    begin
      sck = 1'b0;
      hv = (lanes == 4) ? b[7 - 4 * i -: 4] : {3'b000, b[7 - i]};
      waitClk(half);
      r = {r[6:0], ioIn[1]};
      sck = 1'b1;
      waitClk(half);
    end
  endtask
  // Long deselect lets the mode update land
  task automatic closeFrame();
    sck = idleLvl;
    waitClk(half);
    csN = 1'b1;
    hoe = 1'b0;
    waitClk(4 * half);
  endtask
endmodule
`default_nettype wire

/* dv/sfi_front_bench.sv */
// Self-checking bench of the serial flash front end
`timescale 1ns/1ps
`default_nettype none
module sfi_front_bench;
  import sfi_pkg::*;
  typedef struct packed {logic [7:0] op; logic mode;} sfi_row_t;
  logic        clk, reset_n, hwResetN, csN, sck, fourLineMode, dtrEnable, txDrive, txValid;
  logic        rxIsOpcode, rxValid, rxReady, rxSpace, rxOverrun, addrLoad, addrStep, programMode, wrapEnable;
  logic [3:0]  ioIn, ioOut, ioOeN;
  logic [7:0]  txData, rxData, r;
  logic [23:0] addrValue, curAddr, eraseFirst, eraseLast;
  sfi_lanes_t  bodyLanes;
  sfi_wrap_t   wrapSize;
  sfi_erase_t  eraseKind;
  int          miscompares = 0;
  int          check_count = 0;
  int          lanes = 1;
  sfi_row_t    rows [6] = '{'{8'h3C, 1'b0}, '{8'h35, 1'b1}, '{8'h35, 1'b1}, '{8'hF5, 1'b0}, '{8'hF5, 1'b0},
                            '{8'h35, 1'b1}};
  logic [7:0]  swr [3] = '{8'h35, 8'h66, 8'h99};
  logic [23:0] eMasks [4] = '{24'h00_0FFF, 24'h00_7FFF, 24'h00_FFFF, 24'hFF_FFFF};
  sfi_front #(.FIFO_DEPTH(8)) u_dut (
    .clk, .reset_n, .csN, .sck, .hwResetN, .ioIn, .ioOut, .ioOeN, .wpN(), .holdN(), .fourLineMode,
    .bodyLanes, .dtrEnable, .txDrive, .txData, .txValid, .txReady(), .rxData, .rxIsOpcode, .rxValid,
    .rxReady, .rxSpace, .rxOverrun, .addrLoad, .addrValue, .addrStep, .programMode, .wrapEnable,
    .wrapSize, .eraseKind, .curAddr, .pageBytes(), .pageFull(), .eraseFirst, .eraseLast
  );
  sfi_host u_host (.clk, .csN, .sck, .ioIn, .ioOut, .ioOeN);
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop();
    $display("checks=%0d miscompares=%0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Opcode-only frame
  task automatic frame(input logic [7:0] b, input int n, input logic idle);
    u_host.openFrame(idle);
    u_host.xfer(b, n, r);
    u_host.closeFrame();
  endtask
  // Bounded wait, one handshake, spare edge
  task automatic pop(input logic [8:0] exp);
    int n;
    n = 0;
    while (rxValid !== 1'b1 && n < 200)
    begin
      @(negedge clk);
      n++;
    end
    check({rxIsOpcode, rxData}, exp);
    rxReady = 1'b1;
    @(negedge clk);
    rxReady = 1'b0;
    @(negedge clk);
  endtask
  task automatic addrRun(input logic [23:0] v, input int n);
    addrLoad = 1'b1;
    addrValue = v;
    @(negedge clk);
    addrLoad = 1'b0;
    addrStep = 1'b1;
    repeat (n) @(negedge clk);
    addrStep = 1'b0;
    @(negedge clk);
  endtask
  // Free-running clock
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // Hang limit
  initial
  begin
    repeat (60000) @(posedge clk);
    miscompares++;
    report_and_stop();
  end
  // Main sequence
  initial
  begin
    {reset_n, dtrEnable, txDrive, txValid, rxReady, addrLoad, addrStep, programMode, wrapEnable} = '0;
    hwResetN = 1'b1;
    bodyLanes = LANE_ONE;
    txData = 8'h00;
    addrValue = 24'h00_0000;
    wrapSize = WRAP_8;
    eraseKind = ERASE_4K;
    repeat (16) @(negedge clk);
    reset_n = 1'b1;
    repeat (8) @(negedge clk);
    check(ioOeN, 4'hF);
    // Mode table, both idle levels
    foreach (rows[i])
    begin
      frame(rows[i].op, lanes, i[0]);
      pop({1'b1, rows[i].op});
      check(fourLineMode, rows[i].mode);
      lanes = rows[i].mode ? 4 : 1;
    end
    hwResetN = 1'b0;
    repeat (8) @(negedge clk);
    hwResetN = 1'b1;
    repeat (4) @(negedge clk);
    check(fourLineMode, 1'b0);
    // Software reset from four-line mode
    foreach (swr[k])
    begin
      frame(swr[k], (k > 0) ? 4 : 1, 1'b0);
      pop({1'b1, swr[k]});
    end
    check(fourLineMode, 1'b0);
    // Single-line output: filler, then queued byte; drive only after opcode
    txData = 8'hA5;
    for (int k = 0; k < 2; k++)
    begin
      txValid = k[0];
      u_host.openFrame(1'b0);
      u_host.xfer(8'h03, 1, r);
      txDrive = 1'b1;
      u_host.xfer(8'h00, 1, r);
      u_host.closeFrame();
      txDrive = 1'b0;
      check(r, k ? 8'hA5 : ERASED_BYTE);
      pop({1'b1, 8'h03});
    end
    txValid = 1'b0;
    // Overfill, reader stalled, then drain
    u_host.openFrame(1'b1);
    for (int k = 0; k < 9; k++)
      u_host.xfer(k ? 8'h0F + k[7:0] : 8'h0B, 1, r);
    u_host.closeFrame();
    check(rxSpace, 1'b0);
    check(rxOverrun, 1'b1);
    for (int k = 0; k < 8; k++)
      pop(k ? {1'b0, 8'h0F + k[7:0]} : {1'b1, 8'h0B});
    // Address unit
    programMode = 1'b1;
    addrRun(24'h00_12FE, 3);
    check(curAddr, 24'h00_1201);
    programMode = 1'b0;
    wrapEnable = 1'b1;
    for (int k = 0; k < 4; k++)
    begin
      wrapSize = sfi_wrap_t'(k);
      addrRun(24'h00_0100 + (24'h00_0008 << k) - 24'h00_0002, 3);
      check(curAddr, 24'h00_0101);
    end
    wrapEnable = 1'b0;
    addrRun(24'h12_3455, 1);
    check(curAddr, 24'h12_3456);
    for (int k = 0; k < 4; k++)
    begin
      eraseKind = sfi_erase_t'(k);
      repeat (2) @(negedge clk);
      check(eraseFirst, 24'h12_3456 & ~eMasks[k]);
      check(eraseLast, 24'h12_3456 | eMasks[k]);
    end
    report_and_stop();
  end
endmodule
bind sfi_front sfi_front_checker #(.FIFO_DEPTH(FIFO_DEPTH)) u_chk (
  .clk, .reset_n, .csN, .hwResetN, .ioOeN, .fourLineMode, .bodyLanes, .dtrEnable, .addrLoad, .addrValue,
  .addrStep, .programMode, .wrapEnable, .wrapSize, .eraseKind, .curAddr, .eraseFirst, .eraseLast
);
`default_nettype wire
